/* File: shared/coupler_defs.svh */
// named constants for the channel coupler and its control logic link
`ifndef COUPLER_DEFS_SVH
`define COUPLER_DEFS_SVH
// clock rate and deadman time in seconds
`define CLK_HZ 100000000
`define DEADMAN_S 4
// function code checks: equipment field, legal range 0477 octal
`define FN_EQ_MSB 11
`define FN_EQ_LSB 9
`define FN_EQ_NONE 3'h0
`define FN_LEGAL_MAX 12'h13f
// status request 0012 octal, autoload 0414 octal
`define FN_STATUS_REQ 12'h00a
`define FN_AUTOLOAD 12'h10c
`define FN_LOW_MSB 8
// answer word to an unconnected host: bit 10 set
`define CONN_STATUS_WORD 16'h0400
// processor control bits on output channel 0; path bits 14,15 taken on output channel 4
`define CTL_REPLY 0
`define CTL_DISC 1
`define CTL_INACT 2
`define CTL_DMCLR 3
`define FMT_B12 12
`define FMT_B13 13
`define PATH_B14 14
`define PATH_B15 15
`define FMT_ASSEMBLY0 4'h0
// input channel 0 status bits
`define ST0_FUNC 0
`define ST0_BUSY 1
`define ST0_DEADMAN 2
`define ST0_DATAMODE 3
`define ST0_READY 6
// input channel 3 status bits
`define ST3_WSENSE 9
`define ST3_A_CONN 10
`define ST3_B_CONN 11
`define ST3_PENDING 12
`endif

/* File: shared/coupler_pkg.sv */
// types shared by the coupler and control logic ends
package coupler_pkg;
  typedef enum logic [1:0] {
    PATH_PROC_HOST = 2'h0,
    PATH_CTL_HOST = 2'h1,
    PATH_PROC_CTL = 2'h2,
    PATH_AUTOLOAD = 2'h3
  } path_t;
  typedef enum logic [2:0] {
    AL_IDLE = 3'h0,
    AL_STOP = 3'h1,
    AL_CLEAR = 3'h3,
    AL_FORCE = 3'h2,
    AL_LAUNCH = 3'h6,
    AL_RUN = 3'h7
  } al_state_t;
  typedef enum logic [1:0] {
    SR_IDLE = 2'h0,
    SR_ACT = 2'h1,
    SR_EMPTY = 2'h3
  } sr_state_t;
endpackage

/* File: shared/coupler_link_if.sv */
// data handshake between the coupler and the disk control logic
`timescale 1ns/1ps
interface coupler_link_if;
  logic to_logic_request;
  logic [15:0] to_logic_data;
  logic to_logic_record_end;
  logic to_logic_accept;
  logic from_logic_request;
  logic [15:0] from_logic_data;
  logic from_logic_record_end;
  logic from_logic_accept;
  logic write_sense_n;
  logic halt;
  modport coupler (
    output to_logic_request, to_logic_data, to_logic_record_end, from_logic_accept, halt,
    input to_logic_accept, from_logic_request, from_logic_data, from_logic_record_end,
    input write_sense_n
  );
  modport ctl (
    input to_logic_request, to_logic_data, to_logic_record_end, from_logic_accept, halt,
    output to_logic_accept, from_logic_request, from_logic_data, from_logic_record_end,
    output write_sense_n
  );
endinterface

/* File: rtl/ctl_logic_end.sv */
// control logic end of the coupler data link
`timescale 1ns/1ps
`include "coupler_defs.svh"
module ctl_logic_end import coupler_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // words to send to the coupler
  input wire logic tx_valid,
  input wire logic [15:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // words received from the coupler
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [15:0] rx_data,
  output logic rx_last,
  // input operation start/stop and clear from the coupler
  input wire logic start_input,
  input wire logic end_input,
  output logic halted,
  // coupler link
  coupler_link_if.ctl link
);
  logic req_r;
  logic [15:0] data_r;
  logic last_r;
  logic eor_r;
  logic acc_d_r;
  logic acked_r;
  logic rx_valid_r;
  logic [15:0] rx_data_r;
  logic rx_last_r;
  logic wsense_n_r;
  logic halted_r;

  // only a rising accept answers our request; a standing one belongs to the previous word
  wire tx_done = req_r & link.from_logic_accept & ~acc_d_r;
  wire rx_take = link.to_logic_request & ~acked_r & rx_ready;

  assign tx_ready = ~req_r & ~link.halt;
  assign link.from_logic_request = req_r;
  assign link.from_logic_data = data_r;
  assign link.from_logic_record_end = eor_r;
  assign link.to_logic_accept = rx_take;
  assign link.write_sense_n = wsense_n_r;
  assign rx_valid = rx_valid_r;
  assign rx_data = rx_data_r;
  assign rx_last = rx_last_r;
  assign halted = halted_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= 1'b0;
      data_r <= 16'h0000;
      last_r <= 1'b0;
      eor_r <= 1'b0;
      acc_d_r <= 1'b0;
    end else begin
      acc_d_r <= link.from_logic_accept;
      eor_r <= tx_done & last_r;
      if (link.halt) begin
        req_r <= 1'b0;
      end else if (tx_done) begin
        req_r <= 1'b0;
      end else if (tx_valid & ~req_r) begin
        req_r <= 1'b1;
        data_r <= tx_data;
        last_r <= tx_last;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acked_r <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_data_r <= 16'h0000;
      rx_last_r <= 1'b0;
      halted_r <= 1'b0;
      wsense_n_r <= 1'b1;
    end else begin
      rx_valid_r <= rx_take;
      rx_last_r <= link.to_logic_record_end;
      halted_r <= link.halt;
      if (rx_take) begin
        rx_data_r <= link.to_logic_data;
      end
      // the coupler drops its request one edge after our accept
      acked_r <= link.to_logic_request & (acked_r | rx_take);
      if (link.halt | end_input) begin
        wsense_n_r <= 1'b1;
      end else if (start_input) begin
        wsense_n_r <= 1'b0;
      end
    end
  end
endmodule

/* File: rtl/channel_coupler.sv */
// coupler between host channels, the subsystem processor and the control logic
`timescale 1ns/1ps
`include "coupler_defs.svh"
// Overview of operation
// - processor bits 14,15 select the data path
// - master clear or any taken function restores processor-host path
// - pulse cycle halt before autoload
// - hold block enable low, pulse force, then launch
// - to-logic request held until logic accepts
// - from-logic accept set on take, cleared by request
// - record end on last word or host termination
// - halt on master clear, deadman or autoload
// - logic holds request until accept rises
// - logic holds data stable until accept rises
// - logic pulses record end after last word
// - falling write sense marks input operation start
// - legal code: equipment zero, up to 0477
// - legal function reserves until released
// - first legal function connects; other host barred
// - unconnected status request answered with bit 10
// - other functions held until owner disconnects
// - deadman expiry drops connect, inactive, halt; terminate except on control-logic-host path
// - control bit 3 clears and holds deadman
// - function shown to processor, reply gives inactive
// - autoload resets path, format, halts, prepares processor
// - autoload ends on inactive or deadman, terminate
module channel_coupler import coupler_pkg::*; #(
  parameter bit DUAL_ACCESS = 1'b1,
  parameter int unsigned DEADMAN_CYC = `DEADMAN_S * `CLK_HZ
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host channels, index 0 is host a, index 1 is host b
  input wire logic [1:0] host_func_pulse,
  input wire logic [11:0] host_func_code_a,
  input wire logic [11:0] host_func_code_b,
  input wire logic [1:0] host_activate,
  input wire logic [1:0] host_inactive,
  input wire logic [1:0] host_empty,
  input wire logic host_master_clear,
  input wire logic host_out_valid,
  input wire logic [15:0] host_out_data,
  input wire logic host_out_last,
  output logic host_out_ready,
  output logic [1:0] host_inactive_out,
  output logic [1:0] host_full,
  output logic [15:0] host_in_data,
  // subsystem processor
  input wire logic [15:0] processor_control_lines,
  input wire logic set_out0_n,
  input wire logic set_out4_n,
  input wire logic proc_out_valid,
  input wire logic [15:0] proc_out_data,
  input wire logic proc_out_last,
  output logic proc_out_ready,
  output logic proc_in_valid,
  output logic [15:0] proc_in_data,
  output logic in_record_end,
  output logic [15:0] status_word0,
  output logic [15:0] status_word3,
  output logic processor_cycle_halt_n,
  output logic processor_clear_pulse_n,
  output logic block_input_enable_n,
  output logic forced_instruction_pulse_n,
  output logic instruction_launch_n,
  output logic proc_terminate,
  // control logic link
  coupler_link_if.coupler link
);
  function automatic logic legal_fn(input logic [11:0] c);
    return (c[`FN_EQ_MSB:`FN_EQ_LSB] == `FN_EQ_NONE) && (c <= `FN_LEGAL_MAX);
  endfunction

  logic [1:0] owner_r;
  logic scan_r, func_avail_r, dm_flag_r, pend_v_r, pend_h_r, sr_h_r;
  logic [11:0] pend_code_r;
  logic [8:0] func_code_r;
  path_t path_r;
  logic [3:0] format_r, ctl0_r, ctl0_d_r;
  logic [31:0] dm_cnt_r;
  al_state_t al_st_r;
  sr_state_t sr_st_r;
  logic tl_req_r, tl_last_r, tl_eor_r, fl_acc_r, fl_req_d_r, halt_r;
  logic [15:0] tl_data_r;
  logic ws_d_r, ws_started_r, eor_in_r, term_r;
  logic [1:0] inact_r, full_r;
  logic [15:0] hin_data_r, pin_data_r;
  logic pin_valid_r;

  // function events: a new pulse wins over a held one, scan settles ties
  wire win_b = host_func_pulse[1] & (~host_func_pulse[0] | scan_r);
  wire new_v = |host_func_pulse;
  wire lose_v = &host_func_pulse;
  wire seq_idle = (al_st_r == AL_IDLE) & (sr_st_r == SR_IDLE);
  wire idle = ~func_avail_r & seq_idle;
  wire pend_go = pend_v_r & (owner_r == 2'b00) & ~new_v;
  wire ev_h = new_v ? win_b : pend_h_r;
  wire [11:0] ev_code = new_v ? (win_b ? host_func_code_b : host_func_code_a) : pend_code_r;
  wire [1:0] ev_oh = ev_h ? 2'b10 : 2'b01;
  wire ev_mine = ~DUAL_ACCESS | (owner_r == 2'b00) | (|(owner_r & ev_oh));
  // the barred host may still ask for status while the owner's function waits
  wire ev_v = (new_v | pend_go) & (idle | (seq_idle & ~ev_mine));
  wire ev_ok = ev_v & legal_fn(ev_code);
  wire ev_take = ev_ok & ev_mine;
  wire ev_status = ev_ok & ~ev_mine & (ev_code == `FN_STATUS_REQ);
  wire ev_hold = ev_ok & ~ev_mine & ~ev_status;
  wire ev_autoload = ev_take & (ev_code == `FN_AUTOLOAD);
  wire [1:0] sr_oh = sr_h_r ? 2'b10 : 2'b01;

  // processor replies are set-then-clear of an output channel 0 bit
  wire reply_ev = ctl0_d_r[`CTL_REPLY] & ~ctl0_r[`CTL_REPLY];
  wire disc_ev = ctl0_d_r[`CTL_DISC] & ~ctl0_r[`CTL_DISC];
  wire pinact_ev = ctl0_d_r[`CTL_INACT] & ~ctl0_r[`CTL_INACT];
  wire mclr = host_master_clear;
  wire owner_inact = |(host_inactive & owner_r);
  wire dm_run = (owner_r != 2'b00) & ~ctl0_r[`CTL_DMCLR];
  wire dm_kick = reply_ev | disc_ev | link.to_logic_accept | link.from_logic_request;
  wire dm_exp = dm_run & ~dm_kick & (dm_cnt_r == DEADMAN_CYC - 32'd1);
  wire drop = mclr | owner_inact | disc_ev | pinact_ev | dm_exp;
  wire al_end = (al_st_r == AL_RUN) & (owner_inact | dm_exp);

  wire p_ch = path_r == PATH_CTL_HOST;
  wire p_pc = path_r == PATH_PROC_CTL;
  wire p_ph = (path_r == PATH_PROC_HOST) | (path_r == PATH_AUTOLOAD);
  wire tl_load = ~tl_req_r & ((p_ch & host_out_valid) | (p_pc & proc_out_valid));
  wire fl_take = link.from_logic_request & ~fl_acc_r & (p_ch | p_pc);
  wire ws_fall = ws_d_r & ~link.write_sense_n;

  assign host_out_ready = p_ch ? ~tl_req_r : p_ph;
  assign proc_out_ready = p_pc ? ~tl_req_r : (path_r == PATH_PROC_HOST);
  assign link.to_logic_request = tl_req_r;
  assign link.to_logic_data = tl_data_r;
  assign link.to_logic_record_end = tl_eor_r;
  assign link.from_logic_accept = fl_acc_r;
  assign link.halt = halt_r;
  assign host_inactive_out = inact_r;
  assign host_full = full_r;
  assign host_in_data = hin_data_r;
  assign proc_in_valid = pin_valid_r;
  assign proc_in_data = pin_data_r;
  assign in_record_end = eor_in_r;
  assign proc_terminate = term_r;
  assign processor_cycle_halt_n = al_st_r != AL_STOP;
  assign processor_clear_pulse_n = al_st_r != AL_CLEAR;
  assign forced_instruction_pulse_n = al_st_r != AL_FORCE;
  assign instruction_launch_n = al_st_r != AL_LAUNCH;
  assign block_input_enable_n = al_st_r == AL_IDLE;

  always_comb begin
    status_word0 = 16'h0000;
    status_word0[`ST0_FUNC] = func_avail_r;
    status_word0[`ST0_BUSY] = owner_r != 2'b00;
    status_word0[`ST0_DEADMAN] = dm_flag_r;
    status_word0[`ST0_DATAMODE] = |(owner_r & host_activate);
    status_word0[`ST0_READY] = p_pc | ~tl_req_r;
    status_word3 = 16'h0000;
    status_word3[`FN_LOW_MSB:0] = func_code_r;
    status_word3[`ST3_WSENSE] = ws_started_r;
    status_word3[`ST3_A_CONN] = owner_r[0];
    status_word3[`ST3_B_CONN] = owner_r[1];
    status_word3[`ST3_PENDING] = pend_v_r;
  end

  // connection, function hand-off and deadman
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      owner_r <= 2'b00;
      scan_r <= 1'b0;
      func_avail_r <= 1'b0;
      func_code_r <= 9'h000;
      dm_flag_r <= 1'b0;
      dm_cnt_r <= 32'h0;
      pend_v_r <= 1'b0;
      pend_h_r <= 1'b0;
      pend_code_r <= 12'h000;
      ctl0_r <= 4'h0;
      ctl0_d_r <= 4'h0;
    end else begin
      scan_r <= ~scan_r;
      ctl0_d_r <= ctl0_r;
      if (!set_out0_n) begin
        ctl0_r <= processor_control_lines[3:0];
      end
      dm_cnt_r <= (dm_run & ~dm_kick & ~dm_exp) ? dm_cnt_r + 32'd1 : 32'h0;
      if (drop) begin
        owner_r <= 2'b00;
      end else if (ev_take) begin
        owner_r <= ev_oh;
      end
      if (mclr | ev_take) begin
        dm_flag_r <= 1'b0;
      end
      if (dm_exp) begin
        dm_flag_r <= 1'b1;
      end
      if (reply_ev | drop) begin
        func_avail_r <= 1'b0;
      end
      if (ev_take & ~ev_autoload & ~mclr) begin
        func_avail_r <= 1'b1;
        func_code_r <= ev_code[`FN_LOW_MSB:0];
      end
      if (mclr | (pend_v_r & host_inactive[pend_h_r]) | (pend_go & idle)) begin
        pend_v_r <= 1'b0;
      end else if (DUAL_ACCESS & ~pend_v_r & (ev_hold | (lose_v & idle))) begin
        pend_v_r <= 1'b1;
        pend_h_r <= ev_hold ? ev_h : ~win_b;
        pend_code_r <= ev_hold ? ev_code : (win_b ? host_func_code_a : host_func_code_b);
      end
    end
  end

  // path, format, autoload and status request sequences
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      path_r <= PATH_PROC_HOST;
      format_r <= `FMT_ASSEMBLY0;
      al_st_r <= AL_IDLE;
      sr_st_r <= SR_IDLE;
      sr_h_r <= 1'b0;
    end else begin
      if (mclr | ev_take) begin
        path_r <= PATH_PROC_HOST;
        format_r <= `FMT_ASSEMBLY0;
      end else begin
        if (!set_out4_n) begin
          path_r <= path_t'({processor_control_lines[`PATH_B14],
                             processor_control_lines[`PATH_B15]});
        end
        if (!set_out0_n) begin
          format_r <= processor_control_lines[`PATH_B15:`FMT_B12];
        end
      end
      unique case (al_st_r)
        AL_IDLE: al_st_r <= ev_autoload & ~mclr ? AL_STOP : AL_IDLE;
        AL_STOP: al_st_r <= mclr ? AL_IDLE : AL_CLEAR;
        AL_CLEAR: al_st_r <= mclr ? AL_IDLE : AL_FORCE;
        AL_FORCE: al_st_r <= mclr ? AL_IDLE : AL_LAUNCH;
        AL_LAUNCH: al_st_r <= mclr ? AL_IDLE : AL_RUN;
        AL_RUN: al_st_r <= (mclr | al_end) ? AL_IDLE : AL_RUN;
        default: al_st_r <= AL_IDLE;
      endcase
      if (mclr | (sr_st_r != SR_IDLE & host_inactive[sr_h_r])) begin
        sr_st_r <= SR_IDLE;
      end else begin
        unique case (sr_st_r)
          SR_IDLE: begin
            if (ev_status) begin
              sr_st_r <= SR_ACT;
              sr_h_r <= ev_h;
            end
          end
          SR_ACT: sr_st_r <= host_activate[sr_h_r] ? SR_EMPTY : SR_ACT;
          SR_EMPTY: sr_st_r <= host_empty[sr_h_r] ? SR_IDLE : SR_EMPTY;
          default: sr_st_r <= SR_IDLE;
        endcase
      end
    end
  end

  // data movement and pulses toward host, processor and control logic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tl_req_r <= 1'b0;
      tl_last_r <= 1'b0;
      tl_data_r <= 16'h0000;
      tl_eor_r <= 1'b0;
      fl_acc_r <= 1'b0;
      fl_req_d_r <= 1'b0;
      halt_r <= 1'b0;
      ws_d_r <= 1'b1;
      ws_started_r <= 1'b0;
      eor_in_r <= 1'b0;
      term_r <= 1'b0;
      inact_r <= 2'b00;
      full_r <= 2'b00;
      hin_data_r <= 16'h0000;
      pin_valid_r <= 1'b0;
      pin_data_r <= 16'h0000;
    end else begin
      fl_req_d_r <= link.from_logic_request;
      ws_d_r <= link.write_sense_n;
      halt_r <= mclr | dm_exp | ev_autoload;
      term_r <= (dm_exp & ~p_ch) | al_end;
      eor_in_r <= link.from_logic_record_end;
      inact_r <= ({2{reply_ev | disc_ev | dm_exp}} & owner_r)
               | ({2{ev_status}} & ev_oh)
               | ({2{sr_st_r == SR_EMPTY & host_empty[sr_h_r]}} & sr_oh)
               | ({2{al_st_r == AL_LAUNCH}} & owner_r);
      tl_eor_r <= (link.to_logic_accept & tl_req_r & tl_last_r)
                | (owner_inact & p_ch & ws_started_r);
      if (halt_r | tl_eor_r) begin
        ws_started_r <= 1'b0;
      end
      if (ws_fall) begin
        ws_started_r <= 1'b1;
      end
      if (halt_r | link.to_logic_accept) begin
        tl_req_r <= 1'b0;
      end else if (tl_load) begin
        tl_req_r <= 1'b1;
        tl_data_r <= p_ch ? host_out_data : proc_out_data;
        tl_last_r <= p_ch ? host_out_last : proc_out_last;
      end
      if (fl_take) begin
        fl_acc_r <= 1'b1;
      end else if (link.from_logic_request & ~fl_req_d_r) begin
        fl_acc_r <= 1'b0;
      end
      pin_valid_r <= (host_out_valid & p_ph) | (fl_take & p_pc);
      if (host_out_valid & p_ph) begin
        pin_data_r <= host_out_data;
      end else if (fl_take & p_pc) begin
        pin_data_r <= link.from_logic_data;
      end
      if (sr_st_r == SR_ACT & host_activate[sr_h_r]) begin
        full_r <= sr_oh;
        hin_data_r <= `CONN_STATUS_WORD;
      end else if ((fl_take & p_ch) | (proc_out_valid & path_r == PATH_PROC_HOST)) begin
        full_r <= owner_r;
        hin_data_r <= p_ch ? link.from_logic_data : proc_out_data;
      end else begin
        full_r <= 2'b00;
      end
    end
  end
endmodule

/* File: testbench/coupler_link_monitor.sv */
// link protocol checker between the coupler and control logic ends
`timescale 1ns/1ps
module coupler_link_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link signals
  input wire logic to_logic_request,
  input wire logic [15:0] to_logic_data,
  input wire logic to_logic_record_end,
  input wire logic to_logic_accept,
  input wire logic from_logic_request,
  input wire logic [15:0] from_logic_data,
  input wire logic from_logic_record_end,
  input wire logic from_logic_accept,
  input wire logic write_sense_n,
  input wire logic halt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // halt clears the logic side, so a waiting request may drop then
  wire logic cwait = from_logic_request && !from_logic_accept && !halt;
  req_hold_a:
    assert property (to_logic_request && !to_logic_accept && !halt |=> to_logic_request)
    else $error("to-logic request dropped early");
  data_hold_a:
    assert property (to_logic_request && !to_logic_accept |=> $stable(to_logic_data))
    else $error("to-logic data moved");
  req_drop_a:
    assert property (to_logic_request && to_logic_accept |=> !to_logic_request)
    else $error("to-logic request stuck");
  acc_rise_a:
    assert property ($rose(from_logic_accept) |-> $past(from_logic_request))
    else $error("accept without request");
  acc_clear_a:
    assert property ($rose(from_logic_request) && from_logic_accept |=> !from_logic_accept)
    else $error("accept not cleared");
  creq_hold_a:
    assert property (cwait |=> from_logic_request)
    else $error("from-logic request dropped");
  cob_hold_a:
    assert property (cwait |=> $stable(from_logic_data))
    else $error("from-logic data moved");
  halt_pulse_a:
    assert property (halt |=> !halt && !to_logic_request)
    else $error("halt not a clearing pulse");
  eor_pulse_a:
    assert property (to_logic_record_end |=> !to_logic_record_end)
    else $error("record end not a pulse");
  cover property ($rose(to_logic_request));
  cover property (from_logic_accept && from_logic_record_end);
  cover property ($fell(write_sense_n));
endmodule

/* File: testbench/tb.sv */
// self-checking bench joining the coupler and control logic ends
`timescale 1ns/1ps
module tb;
  // short deadman keeps the timeout cases within a few hundred cycles
  localparam int unsigned DM = 50;
  logic mclk = 1'b0, rst_n = 1'b0, mc = 1'b0, hv = 1'b0, hl = 1'b0, s0n = 1'b1, s4n = 1'b1;
  logic tv = 1'b0, tl = 1'b0, rr = 1'b1, si = 1'b0, pv = 1'b0, seen_clr = 1'b0;
  logic [1:0] fp = 2'h0, act = 2'h0, ina = 2'h0, emp = 2'h0;
  logic [11:0] fc = 12'h0;
  logic [15:0] hd = 16'h0, cl = 16'h0, td = 16'h0;
  logic [13:0] seen = 14'h0;
  int err_count = 0;
  int checks = 0;
  logic hrdy, prdy, trdy, piv, ire, chn, cpn, ben, ffn, gon, pt, rxv, rxl, hal;
  logic [1:0] hio, hfu;
  logic [15:0] hid, pid, sw0, sw3, rxd;
  wire logic [13:0] ev = {hfu, hio, rxl, rxv, ire, piv, hal, pt, ~gon, ~ffn, ~cpn, ~chn};
  coupler_link_if lnk ();
  always #5 mclk = ~mclk;
  // one-cycle pulses are latched here and cleared between steps
  always @(posedge mclk) seen <= seen_clr ? ev : (seen | ev);
  channel_coupler #(.DEADMAN_CYC(DM)) channel_coupler_inst (
    .mclk(mclk), .rst_n(rst_n), .host_func_pulse(fp), .host_func_code_a(fc),
    .host_func_code_b(fc), .host_activate(act), .host_inactive(ina), .host_empty(emp),
    .host_master_clear(mc), .host_out_valid(hv), .host_out_data(hd), .host_out_last(hl),
    .host_out_ready(hrdy), .host_inactive_out(hio), .host_full(hfu), .host_in_data(hid),
    .processor_control_lines(cl), .set_out0_n(s0n), .set_out4_n(s4n), .proc_out_valid(pv),
    .proc_out_data(hd), .proc_out_last(hl), .proc_out_ready(prdy), .proc_in_valid(piv),
    .proc_in_data(pid), .in_record_end(ire), .status_word0(sw0), .status_word3(sw3),
    .processor_cycle_halt_n(chn), .processor_clear_pulse_n(cpn), .block_input_enable_n(ben),
    .forced_instruction_pulse_n(ffn), .instruction_launch_n(gon), .proc_terminate(pt),
    .link(lnk));
  ctl_logic_end ctl_logic_end_inst (
    .mclk(mclk), .rst_n(rst_n), .tx_valid(tv), .tx_data(td), .tx_last(tl), .tx_ready(trdy),
    .rx_ready(rr), .rx_valid(rxv), .rx_data(rxd), .rx_last(rxl), .start_input(si),
    .end_input(1'b0), .halted(hal), .link(lnk));
  coupler_link_monitor coupler_link_monitor_inst (
    .mclk(mclk), .rst_n(rst_n), .to_logic_request(lnk.to_logic_request),
    .to_logic_data(lnk.to_logic_data), .to_logic_record_end(lnk.to_logic_record_end),
    .to_logic_accept(lnk.to_logic_accept), .from_logic_request(lnk.from_logic_request),
    .from_logic_data(lnk.from_logic_data), .from_logic_record_end(lnk.from_logic_record_end),
    .from_logic_accept(lnk.from_logic_accept), .write_sense_n(lnk.write_sense_n),
    .halt(lnk.halt));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic clr;
    @(posedge mclk);
    seen_clr <= 1'b1;
    @(posedge mclk);
    seen_clr <= 1'b0;
  endtask
  task automatic func(input logic [1:0] h, input logic [11:0] c);
    @(posedge mclk);
    fp <= h;
    fc <= c;
    @(posedge mclk);
    fp <= 2'h0;
  endtask
  // bits count only while the strobe is low; set then clear takes two calls
  task automatic ctl(input logic [15:0] v, input logic p4);
    @(posedge mclk);
    cl <= v;
    s0n <= p4;
    s4n <= !p4;
    @(posedge mclk);
    s0n <= 1'b1;
    s4n <= 1'b1;
  endtask
  task automatic hword(input logic [15:0] d, input logic last);
    @(posedge mclk);
    hv <= 1'b1;
    hd <= d;
    hl <= last;
    @(posedge mclk);
    hv <= 1'b0;
    hl <= 1'b0;
  endtask
  task automatic tx(input logic [15:0] d, input logic last);
    logic k;
    @(posedge mclk);
    tv <= 1'b1;
    td <= d;
    tl <= last;
    do begin
      @(negedge mclk);
      k = trdy;
      @(posedge mclk);
    end while (!k);
    tv <= 1'b0;
    tl <= 1'b0;
  endtask
  task automatic finish_test;
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
    chk(sw0[2:0], 16'h0);
    chk(hrdy, 16'h1);
    func(2'h1, 12'h200);
    func(2'h1, 12'h140);
    cyc(2);
    chk(sw0[0], 16'h0);
    func(2'h1, 12'h13f);
    cyc(2);
    chk(sw0[1:0], 16'h3);
    chk(sw3[10], 16'h1);
    chk(sw3[8:0], 16'h13f);
    clr;
    func(2'h2, 12'h00a);
    cyc(2);
    chk(seen[11], 16'h1);
    act <= 2'h2;
    cyc(3);
    chk(seen[13], 16'h1);
    chk(hid, 16'h0400);
    clr;
    emp <= 2'h2;
    cyc(1);
    emp <= 2'h0;
    act <= 2'h0;
    cyc(2);
    chk(seen[11], 16'h1);
    clr;
    func(2'h2, 12'h001);
    cyc(3);
    chk(seen[11], 16'h0);
    ctl(16'h0001, 1'b0);
    ctl(16'h0000, 1'b0);
    cyc(3);
    chk(seen[10], 16'h1);
    ctl(16'h0002, 1'b0);
    ctl(16'h0000, 1'b0);
    cyc(3);
    chk(sw3[11:10], 16'h2);
    chk(sw3[8:0], 16'h001);
    ctl(16'h0002, 1'b0);
    ctl(16'h0000, 1'b0);
    cyc(3);
    chk(sw0[1], 16'h0);
    func(2'h1, 12'h001);
    ctl(16'h0008, 1'b0);
    cyc(DM + 20);
    chk(sw0[2], 16'h0);
    ctl(16'h0001, 1'b0);
    ctl(16'h0000, 1'b0);
    cyc(3);
    clr;
    cyc(DM + 8);
    chk(sw0[2:1], 16'h2);
    chk(seen[11:10], 16'h1);
    chk(seen[5:4], 16'h3);
    ctl(16'h8000, 1'b1);
    rr <= 1'b0;
    hword(16'h1234, 1'b0);
    cyc(2);
    chk(hrdy, 16'h0);
    rr <= 1'b1;
    cyc(3);
    chk(rxd, 16'h1234);
    clr;
    hword(16'hbeef, 1'b1);
    cyc(4);
    chk(rxd, 16'hbeef);
    chk(seen[9], 16'h1);
    ctl(16'h4000, 1'b1);
    clr;
    tx(16'h5a5a, 1'b0);
    cyc(3);
    chk(pid, 16'h5a5a);
    tx(16'h0f0f, 1'b1);
    cyc(6);
    chk(pid, 16'h0f0f);
    chk(seen[7:6], 16'h3);
    chk(hrdy, 16'h0);
    chk(prdy, 16'h1);
    @(posedge mclk);
    pv <= 1'b1;
    hd <= 16'hc3c3;
    @(posedge mclk);
    pv <= 1'b0;
    cyc(3);
    chk(rxd, 16'hc3c3);
    si <= 1'b1;
    cyc(1);
    si <= 1'b0;
    cyc(2);
    chk(lnk.write_sense_n, 16'h0);
    chk(sw3[9], 16'h1);
    clr;
    mc <= 1'b1;
    cyc(1);
    mc <= 1'b0;
    cyc(3);
    chk(hrdy, 16'h1);
    chk(seen[5], 16'h1);
    ctl(16'hc000, 1'b1);
    cyc(1);
    chk(hrdy, 16'h1);
    ctl(16'h8000, 1'b1);
    clr;
    func(2'h1, 12'h10c);
    cyc(3);
    chk(ben, 16'h0);
    chk(hrdy, 16'h1);
    cyc(6);
    chk(seen[5:0], 16'h2f);
    chk(seen[10], 16'h1);
    hword(16'h0777, 1'b0);
    cyc(3);
    chk(pid, 16'h0777);
    clr;
    ina <= 2'h1;
    cyc(1);
    ina <= 2'h0;
    cyc(3);
    chk(seen[4], 16'h1);
    chk(ben, 16'h1);
    finish_test;
  end
  initial begin
    cyc(2000);
    err_count++;
    finish_test;
  end
endmodule
